// *** vds_defs.svh ***
// Purpose: offsets, field layouts, reset values and constants of the slicer setup block
// Assumes: 8-bit subaddressed register port in front of the block
// Notes:   definitions only
`ifndef VDS_DEFS_SVH
`define VDS_DEFS_SVH

`define VDS_ADDR_IMASK      8'h2d
`define VDS_ADDR_CTRL1      8'h40
`define VDS_ADDR_LT_FIRST   8'h41
`define VDS_ADDR_LT21       8'h54
`define VDS_ADDR_LT_LAST    8'h57
`define VDS_ADDR_FCODE      8'h58
`define VDS_ADDR_SLICE_H_OFFSET       8'h59
`define VDS_ADDR_SLICE_V_OFFSET       8'h5a
`define VDS_ADDR_SLICE_FIELD_OFFSET       8'h5b
`define VDS_ADDR_RSV_A      8'h5c
`define VDS_ADDR_HDR        8'h5d
`define VDS_ADDR_SLICED_ID_CODE       8'h5e
`define VDS_ADDR_RSV_B      8'h5f
`define VDS_ADDR_ST0        8'h60
`define VDS_ADDR_ST1        8'h61
`define VDS_ADDR_ST2        8'h62

`define VDS_RST_IMASK       8'h00
`define VDS_RST_CTRL1       8'h40
`define VDS_RST_LT          8'hff
`define VDS_RST_LT21        8'h5f
`define VDS_RST_FCODE       8'h00
`define VDS_RST_SLICE_H_OFFSET        8'h47
`define VDS_RST_SLICE_V_OFFSET        8'h06
`define VDS_RST_SLICE_FIELD_OFFSET        8'h83
`define VDS_RST_HDR         8'h3e
`define VDS_RST_SLICED_ID_CODE        8'h00
// shadow offsets as the register reset values combine them
`define VDS_RST_SLICE_H_OFFSET_FULL   11'h347
`define VDS_RST_SLICE_V_OFFSET_FULL   9'h006

// writable bits; reserved positions store and read as zero
`define VDS_MASK_IMASK      8'h1d
`define VDS_MASK_CTRL1      8'h70
`define VDS_MASK_SLICE_FIELD_OFFSET       8'hd7
`define VDS_MASK_HDR        8'hbf
`define VDS_MASK_SLICED_ID_CODE       8'h3f

`define VDS_NUM_LINES       23
`define VDS_LT21_INDEX      19
`define VDS_VIDEO_TEXT_ARBITRATION_SEL_ON         2'h3
`define VDS_ITU_HID         6'h3e
`define VDS_LT_VIDEO        4'hf
`define VDS_SYNC_ONES       8'hff
`define VDS_SYNC_ZERO       8'h00
`define VDS_HDR_LAST        3'h4
`define VDS_TRL_LAST        3'h3

`endif

// *** vds_pkg.sv ***
// Purpose: types shared by the slicer setup block and its tests
// Assumes: nothing
// Notes:   constants live in vds_defs.svh
package vds_pkg;

	typedef enum logic [1:0] {
		ST_PASS = 2'b00,
		ST_HDR  = 2'b01,
		ST_DATA = 2'b10,
		ST_TRL  = 2'b11
	} vds_state_t;

	// one sliced byte, last marks the end of a line's payload
	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} vds_word_t;

	typedef struct packed {
		logic       framing8_valid;
		logic       framing7_valid;
		logic       program_service_valid;
		logic       pp_valid_flag;
		logic       caption_valid;
		logic [3:0] data_type_code;
	} vds_detect_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vds_reg_req_t;

endpackage

// *** vds_fifo.sv ***
// Purpose: small FIFO for sliced bytes between slicer core and merger
// Assumes: DEPTH a power of two, at least 2
// Notes:   in_ready and out_valid come from flops
`timescale 1ns/1ps
module vds_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
			$error("vds_fifo: DEPTH must be a power of two of at least 2");
		end
	endgenerate

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   cnt_reg;
	logic [AW:0]   cnt_next;
	wire           push = in_valid && in_ready;
	wire           pop  = out_valid && out_ready;

	assign cnt_next = (push && !pop) ? cnt_reg + 1'b1 :
	                  (!push && pop) ? cnt_reg - 1'b1 : cnt_reg;
	assign out_data = mem[rd_ptr_reg];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			in_ready   <= 1'b1;
			out_valid  <= 1'b0;
		end else begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			cnt_reg    <= cnt_next;
			in_ready   <= cnt_next != (AW+1)'(DEPTH);
			out_valid  <= cnt_next != '0;
		end
	end
endmodule

// *** vds_slicer_setup.sv ***
// Purpose: VBI data slicer setup, status capture and sliced data merge
// Assumes: video, slicer core and formatter run on ref_clk
// Notes:   register port answers a read one clock later
`include "vds_defs.svh"
`timescale 1ns/1ps

// Summary of operation
// - sliced packet is appended after each scaled line when regions overlap.
// - one eight-bit line type register per line 2 to 24, consecutive subaddresses.
// - line 21 resets to 5F, others FF: captions line 21 field 1.
// - packets framed by sync codes; header id 3E sets code MSB.
// - header register: field reference bit 7, bit 6 zero, id bits 5:0.
// - horizontal offset is eleven bits, top three from field offset bits 2:0.
// - vertical offset is nine bits, ninth bit from field offset bit 4.
// - field offset register keeps field offset bit 7, select bit 6.
// - sliced id code occupies bits 5:0, upper bits read zero.
// - status byte 0 reports five valid flags in bits 6 to 2.
// - status bytes 1 and 2 report field flag, line number, type.
// - mask register gates program service, pp, caption and FIFO error events.
module vds_slicer_setup #(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	input  wire vds_pkg::vds_reg_req_t reg_req,
	output logic [7:0]               reg_rdata,
	input  wire logic [1:0]          video_text_arbitration_sel,
	input  wire logic                field_start,
	input  wire logic                field_id,
	input  wire logic                line_start,
	input  wire logic                scl_window,
	input  wire logic                vid_valid,
	input  wire logic [7:0]          vid_data,
	input  wire logic                vid_line_end,
	output logic                     vid_ready,
	input  wire logic                slc_byte_valid,
	input  wire vds_pkg::vds_word_t  slc_byte,
	output logic                     slc_byte_ready,
	input  wire logic                slc_done,
	input  wire vds_pkg::vds_detect_t slc_detect,
	output logic                     slc_enable,
	output logic [3:0]               slc_line_type,
	output logic [10:0]              slc_h_offset,
	output logic [7:0]               slc_framing_code,
	output logic                     slc_field_offset,
	output logic                     slc_select_a,
	output logic [3:0]               slc_flag_event,
	output logic                     out_valid,
	output logic [7:0]               out_data,
	input  wire logic                out_ready
);
	import vds_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [7:0]  imask_reg;
	logic [7:0]  ctrl1_reg;
	logic [7:0]  lt_reg [`VDS_NUM_LINES];
	logic [7:0]  fcode_reg;
	logic [7:0]  slice_h_offset_reg;
	logic [7:0]  slice_v_offset_reg;
	logic [7:0]  slice_field_offset_reg;
	logic [7:0]  hdr_reg;
	logic [7:0]  sliced_id_code_reg;
	logic [7:0]  st0_reg;
	logic [7:0]  st1_reg;
	logic [7:0]  st2_reg;
	logic [7:0]  sh_lt_reg [`VDS_NUM_LINES];
	logic [10:0] sh_slice_h_offset_reg;
	logic [8:0]  sh_slice_v_offset_reg;
	logic        field1_reg;
	logic [8:0]  line_cnt_reg;
	vds_state_t  state_reg;
	vds_state_t  state_next;
	logic [2:0]  idx_reg;
	logic [2:0]  idx_next;
	logic [3:0]  pkt_type_reg;
	logic        emit;
	logic [7:0]  emit_byte;
	logic        fifo_pop;
	logic        fifo_valid;
	vds_word_t   fifo_word;
	logic        out_valid_next;

	////////////////////////////////////////////////////////////////////////
	// register port decode
	wire       wr       = reg_req.wr;
	wire [7:0] addr     = reg_req.addr;
	wire [7:0] wdata    = reg_req.wdata;
	wire       is_lt    = addr >= `VDS_ADDR_LT_FIRST && addr <= `VDS_ADDR_LT_LAST;
	wire [4:0] lt_idx   = 5'(addr - `VDS_ADDR_LT_FIRST);
	wire       wr_lt    = wr && is_lt;
	wire       wr_imask = wr && addr == `VDS_ADDR_IMASK;
	wire       wr_ctrl1 = wr && addr == `VDS_ADDR_CTRL1;
	wire       wr_fcode = wr && addr == `VDS_ADDR_FCODE;
	wire       wr_slice_h_offset  = wr && addr == `VDS_ADDR_SLICE_H_OFFSET;
	wire       wr_slice_v_offset  = wr && addr == `VDS_ADDR_SLICE_V_OFFSET;
	wire       wr_slice_field_offset  = wr && addr == `VDS_ADDR_SLICE_FIELD_OFFSET;
	wire       wr_hdr   = wr && addr == `VDS_ADDR_HDR;
	wire       wr_sliced_id_code  = wr && addr == `VDS_ADDR_SLICED_ID_CODE;

	// reserved, status and unmapped subaddresses read as zero or state
	wire [7:0] rdata_sel =
		is_lt                     ? lt_reg[lt_idx] :
		addr == `VDS_ADDR_IMASK   ? imask_reg :
		addr == `VDS_ADDR_CTRL1   ? ctrl1_reg :
		addr == `VDS_ADDR_FCODE   ? fcode_reg :
		addr == `VDS_ADDR_SLICE_H_OFFSET    ? slice_h_offset_reg :
		addr == `VDS_ADDR_SLICE_V_OFFSET    ? slice_v_offset_reg :
		addr == `VDS_ADDR_SLICE_FIELD_OFFSET    ? slice_field_offset_reg :
		addr == `VDS_ADDR_HDR     ? hdr_reg :
		addr == `VDS_ADDR_SLICED_ID_CODE    ? sliced_id_code_reg :
		addr == `VDS_ADDR_ST0     ? st0_reg :
		addr == `VDS_ADDR_ST1     ? st1_reg :
		addr == `VDS_ADDR_ST2     ? st2_reg : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			for (int i = 0; i < `VDS_NUM_LINES; i++) begin
				lt_reg[i] <= (i == `VDS_LT21_INDEX) ? `VDS_RST_LT21 : `VDS_RST_LT;
			end
		end else if (wr_lt) begin
			lt_reg[lt_idx] <= wdata;
		end
	end

	// control registers with their write masks, and the registered read data
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			imask_reg <= `VDS_RST_IMASK;
			ctrl1_reg <= `VDS_RST_CTRL1;
			fcode_reg <= `VDS_RST_FCODE;
			slice_h_offset_reg  <= `VDS_RST_SLICE_H_OFFSET;
			slice_v_offset_reg  <= `VDS_RST_SLICE_V_OFFSET;
			slice_field_offset_reg  <= `VDS_RST_SLICE_FIELD_OFFSET;
			hdr_reg   <= `VDS_RST_HDR;
			sliced_id_code_reg  <= `VDS_RST_SLICED_ID_CODE;
			reg_rdata <= 8'h00;
		end else begin
			imask_reg <= wr_imask ? (wdata & `VDS_MASK_IMASK) : imask_reg;
			ctrl1_reg <= wr_ctrl1 ? (wdata & `VDS_MASK_CTRL1) : ctrl1_reg;
			fcode_reg <= wr_fcode ? wdata : fcode_reg;
			slice_h_offset_reg  <= wr_slice_h_offset ? wdata : slice_h_offset_reg;
			slice_v_offset_reg  <= wr_slice_v_offset ? wdata : slice_v_offset_reg;
			slice_field_offset_reg  <= wr_slice_field_offset ? (wdata & `VDS_MASK_SLICE_FIELD_OFFSET) : slice_field_offset_reg;
			hdr_reg   <= wr_hdr ? (wdata & `VDS_MASK_HDR) : hdr_reg;
			sliced_id_code_reg  <= wr_sliced_id_code ? (wdata & `VDS_MASK_SLICED_ID_CODE) : sliced_id_code_reg;
			reg_rdata <= reg_req.rd ? rdata_sel : reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field timing and per-field settings
	wire [10:0] slice_h_offset_full = {slice_field_offset_reg[2:0], slice_h_offset_reg};
	wire [8:0]  slice_v_offset_full = {slice_field_offset_reg[4], slice_v_offset_reg};

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sh_slice_h_offset_reg  <= `VDS_RST_SLICE_H_OFFSET_FULL;
			sh_slice_v_offset_reg  <= `VDS_RST_SLICE_V_OFFSET_FULL;
			field1_reg   <= 1'b1;
			line_cnt_reg <= 9'h000;
			for (int i = 0; i < `VDS_NUM_LINES; i++) begin
				sh_lt_reg[i] <= `VDS_RST_LT;
			end
		end else if (field_start) begin
			sh_slice_h_offset_reg  <= slice_h_offset_full;
			sh_slice_v_offset_reg  <= slice_v_offset_full;
			field1_reg   <= field_id == hdr_reg[7];
			line_cnt_reg <= 9'h001;
			for (int i = 0; i < `VDS_NUM_LINES; i++) begin
				sh_lt_reg[i] <= lt_reg[i];
			end
		end else if (line_start && line_cnt_reg != 9'h1ff) begin
			line_cnt_reg <= line_cnt_reg + 9'h001;
		end
	end

	wire [8:0] rel_line  = line_cnt_reg - sh_slice_v_offset_reg;
	wire       in_region = line_cnt_reg >= sh_slice_v_offset_reg && rel_line < 9'(`VDS_NUM_LINES);
	wire [7:0] cur_lt    = sh_lt_reg[rel_line[4:0]];
	// high nibble field 1, low nibble field 2
	wire [3:0] cur_type  = field1_reg ? cur_lt[7:4] : cur_lt[3:0];
	wire       active    = video_text_arbitration_sel == `VDS_VIDEO_TEXT_ARBITRATION_SEL_ON;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			slc_enable       <= 1'b0;
			slc_line_type    <= `VDS_LT_VIDEO;
			slc_h_offset     <= 11'h000;
			slc_framing_code <= 8'h00;
			slc_field_offset <= 1'b0;
			slc_select_a     <= 1'b0;
		end else begin
			slc_enable       <= active && in_region && cur_type != `VDS_LT_VIDEO;
			slc_line_type    <= in_region ? cur_type : `VDS_LT_VIDEO;
			slc_h_offset     <= sh_slice_h_offset_reg;
			slc_framing_code <= fcode_reg;
			slc_field_offset <= slice_field_offset_reg[7];
			slc_select_a     <= slice_field_offset_reg[6];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status capture and masked events
	wire fifo_err = slc_byte_valid && !slc_byte_ready;

	// field flag, line number, data type
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st0_reg        <= 8'h00;
			st1_reg        <= 8'h00;
			st2_reg        <= 8'h00;
			slc_flag_event <= 4'h0;
		end else begin
			if (slc_done) begin
				st0_reg <= {1'b0, slc_detect.framing8_valid, slc_detect.framing7_valid,
				            slc_detect.program_service_valid, slc_detect.pp_valid_flag,
				            slc_detect.caption_valid, 2'b00};
				st1_reg <= {2'b00, !field1_reg, line_cnt_reg[8:4]};
				st2_reg <= {line_cnt_reg[3:0], slc_detect.data_type_code};
			end
			slc_flag_event <= {slc_done && slc_detect.program_service_valid && imask_reg[4],
			                   slc_done && slc_detect.pp_valid_flag && imask_reg[3],
			                   slc_done && slc_detect.caption_valid && imask_reg[2],
			                   fifo_err && imask_reg[0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sliced byte buffer
	vds_fifo #(
		.W     ($bits(vds_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (slc_byte_valid),
		.in_data   (slc_byte),
		.in_ready  (slc_byte_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_word),
		.out_ready (fifo_pop)
	);

	////////////////////////////////////////////////////////////////////////
	// output merge: video, then framed sliced packet
	// code MSB follows header id
	wire       fc_msb    = hdr_reg[5:0] == `VDS_ITU_HID;
	wire [7:0] sav_code  = {fc_msb, !field1_reg, 1'b0, pkt_type_reg, 1'b0};
	wire [7:0] eav_code  = {fc_msb, !field1_reg, 1'b1, pkt_type_reg, 1'b0};
	wire [7:0] hdr_byte  = idx_reg == 3'h0 ? `VDS_SYNC_ONES :
	                       idx_reg == 3'h3 ? sav_code :
	                       idx_reg == 3'h4 ? sliced_id_code_reg : `VDS_SYNC_ZERO;
	wire [7:0] trl_byte  = idx_reg == 3'h0 ? `VDS_SYNC_ONES :
	                       idx_reg == 3'h3 ? eav_code : `VDS_SYNC_ZERO;
	wire       slot_free = !out_valid || out_ready;
	wire       take_vid  = vid_valid && vid_ready;
	// overlap of slicer and scaler regions
	wire       merge_ok  = active && scl_window && in_region && fifo_valid;

	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		emit       = 1'b0;
		emit_byte  = out_data;
		fifo_pop   = 1'b0;
		case (state_reg)
			ST_PASS: begin
				if (take_vid) begin
					emit      = 1'b1;
					emit_byte = vid_data;
					if (vid_line_end && merge_ok) begin
						state_next = ST_HDR;
						idx_next   = 3'h0;
					end
				end
			end
			ST_HDR: begin
				if (slot_free) begin
					emit      = 1'b1;
					emit_byte = hdr_byte;
					idx_next  = idx_reg + 3'h1;
					if (idx_reg == `VDS_HDR_LAST) begin
						state_next = ST_DATA;
					end
				end
			end
			ST_DATA: begin
				if (slot_free && fifo_valid) begin
					emit      = 1'b1;
					emit_byte = fifo_word.data;
					fifo_pop  = 1'b1;
					if (fifo_word.last) begin
						state_next = ST_TRL;
						idx_next   = 3'h0;
					end
				end
			end
			ST_TRL: begin
				if (slot_free) begin
					emit      = 1'b1;
					emit_byte = trl_byte;
					idx_next  = idx_reg + 3'h1;
					if (idx_reg == `VDS_TRL_LAST) begin
						state_next = ST_PASS;
					end
				end
			end
			default: begin
				state_next = ST_PASS;
			end
		endcase
	end

	assign out_valid_next = emit || (out_valid && !out_ready);

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg    <= ST_PASS;
			idx_reg      <= 3'h0;
			pkt_type_reg <= `VDS_LT_VIDEO;
			out_valid    <= 1'b0;
			out_data     <= 8'h00;
			vid_ready    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			idx_reg      <= idx_next;
			pkt_type_reg <= (state_reg == ST_PASS) ? cur_type : pkt_type_reg;
			out_valid    <= out_valid_next;
			out_data     <= emit ? emit_byte : out_data;
			vid_ready    <= state_next == ST_PASS && !out_valid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_gate;
		@(posedge ref_clk) disable iff (!rstn)
		slc_enable |-> $past(video_text_arbitration_sel) == `VDS_VIDEO_TEXT_ARBITRATION_SEL_ON;
	endproperty
	a_gate: assert property (p_gate) else $error("slicer enabled while gate off");

	property p_append;
		@(posedge ref_clk) disable iff (!rstn)
		state_reg == ST_PASS && take_vid && vid_line_end && merge_ok
		|=> state_reg == ST_HDR ##1 (state_reg == ST_HDR)[*4];
	endproperty
	a_append: assert property (p_append) else $error("packet not started");

	property p_line_write;
		@(posedge ref_clk) disable iff (!rstn)
		wr_lt |=> lt_reg[$past(lt_idx)] == $past(wdata);
	endproperty
	a_line_write: assert property (p_line_write) else $error("line type lost");

	property p_lt21_reset;
		@(posedge ref_clk) disable iff (!rstn)
		$past(!rstn) |-> lt_reg[`VDS_LT21_INDEX] == `VDS_RST_LT21 && lt_reg[0] == `VDS_RST_LT;
	endproperty
	a_lt21_reset: assert property (p_lt21_reset) else $error("line type reset wrong");

	property p_code_msb;
		@(posedge ref_clk) disable iff (!rstn)
		state_reg == ST_HDR && idx_reg == 3'h3 && emit |=> out_data[7] == $past(fc_msb);
	endproperty
	a_code_msb: assert property (p_code_msb) else $error("framing code msb wrong");

	property p_hdr_layout;
		@(posedge ref_clk) disable iff (!rstn)
		wr_hdr |=> hdr_reg[6] == 1'b0 && hdr_reg[5:0] == $past(wdata[5:0])
		       && hdr_reg[7] == $past(wdata[7]);
	endproperty
	a_hdr_layout: assert property (p_hdr_layout) else $error("header register wrong");

	property p_slice_h_offset;
		@(posedge ref_clk) disable iff (!rstn)
		field_start |-> ##2 slc_h_offset == $past(slice_h_offset_full, 2);
	endproperty
	a_slice_h_offset: assert property (p_slice_h_offset) else $error("horizontal offset wrong");

	property p_slice_v_offset;
		@(posedge ref_clk) disable iff (!rstn)
		field_start |=> sh_slice_v_offset_reg == $past(slice_v_offset_full);
	endproperty
	a_slice_v_offset: assert property (p_slice_v_offset) else $error("vertical offset wrong");

	property p_sliced_id_code;
		@(posedge ref_clk) disable iff (!rstn)
		wr_sliced_id_code |=> sliced_id_code_reg == {2'b00, $past(wdata[5:0])};
	endproperty
	a_sliced_id_code: assert property (p_sliced_id_code) else $error("sliced id wrong");

	property p_status;
		@(posedge ref_clk) disable iff (!rstn)
		slc_done |=> st0_reg[6:2] == $past(slc_detect[8:4])
		          && st2_reg == {$past(line_cnt_reg[3:0]), $past(slc_detect.data_type_code)};
	endproperty
	a_status: assert property (p_status) else $error("status capture wrong");

	property p_mask;
		@(posedge ref_clk) disable iff (!rstn)
		slc_done && slc_detect.caption_valid |=> slc_flag_event[1] == $past(imask_reg[2]);
	endproperty
	a_mask: assert property (p_mask) else $error("caption event mask wrong");

	property p_hold;
		@(posedge ref_clk) disable iff (!rstn)
		!field_start |=> $stable(sh_slice_v_offset_reg) && $stable(sh_slice_h_offset_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("offsets changed mid-field");

	property p_st_ro;
		@(posedge ref_clk) disable iff (!rstn)
		!slc_done |=> $stable(st0_reg) && $stable(st1_reg) && $stable(st2_reg);
	endproperty
	a_st_ro: assert property (p_st_ro) else $error("status changed without data");

	c_packet: cover property (@(posedge ref_clk) disable iff (!rstn)
		state_reg == ST_TRL && state_next == ST_PASS);
	c_caption: cover property (@(posedge ref_clk) disable iff (!rstn)
		slc_done && slc_detect.caption_valid);
	c_fifo_full: cover property (@(posedge ref_clk) disable iff (!rstn)
		slc_byte_valid && !slc_byte_ready);
endmodule

// *** vds_core_model.sv ***
// Purpose: stand-in for slicer core and output formatter
// Assumes: all drives change at the falling edge of ref_clk
// Notes:   stall makes the sink accept every other cycle
`timescale 1ns/1ps
module vds_core_model (
	input  wire logic          ref_clk,
	output vds_pkg::vds_word_t   slc_byte,
	output logic               slc_byte_valid,
	input  wire logic          slc_byte_ready,
	output logic               slc_done,
	output vds_pkg::vds_detect_t slc_detect,
	output logic               out_ready,
	input  wire logic          stall
);
	import vds_pkg::*;
	initial begin
		slc_byte = '0;
		slc_byte_valid = 1'b0;
		slc_done = 1'b0;
		slc_detect = '0;
		out_ready = 1'b1;
	end
	always @(negedge ref_clk) begin
		out_ready <= !stall || !out_ready;
	end
	// once: offer for one cycle even while refused
	task automatic push(input logic [7:0] d, input logic l, input logic once);
		@(negedge ref_clk);
		slc_byte = '{l, d};
		slc_byte_valid = 1'b1;
		while (!once && !slc_byte_ready) @(negedge ref_clk);
		@(negedge ref_clk);
		slc_byte_valid = 1'b0;
		slc_byte.data = ~d;
	endtask
	task automatic done(input vds_detect_t v);
		@(negedge ref_clk);
		slc_detect = v;
		slc_done = 1'b1;
		@(negedge ref_clk);
		slc_done = 1'b0;
		slc_detect = ~v;
	endtask
endmodule

// *** vds_slicer_setup_bench.sv ***
// Purpose: self-checking bench for the slicer setup block
// Assumes: FIFO_DEPTH 4, far side modelled by vds_core_model
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
module vds_slicer_setup_bench;
	import vds_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	vds_reg_req_t reg_req = '0;
	logic [7:0] reg_rdata, fc, od;
	logic [7:0] vid_data = 8'h00;
	logic [1:0] sel = 2'h0;
	logic fs = 0, fid = 0, ls = 0, scl = 0, vv = 0, vle = 0, stall = 0;
	logic vid_ready, sbv, sbr, sdn, en, slice_field_offset, sela, ov, ordy;
	logic [3:0] lt, ev;
	logic [10:0] slice_h_offset;
	vds_word_t sb;
	vds_detect_t sdet;
	int n_errors = 0;
	int check_count = 0;
	logic [7:0] ra[13] = '{8'h40, 8'h41, 8'h53, 8'h54, 8'h57, 8'h58, 8'h59, 8'h5a,
		8'h5b, 8'h5d, 8'h5e, 8'h5c, 8'h2d};
	logic [7:0] rv[13] = '{8'h40, 8'hff, 8'hff, 8'h5f, 8'hff, 8'h00, 8'h47, 8'h06,
		8'h83, 8'h3e, 8'h00, 8'h00, 8'h00};
	logic [7:0] wa[8] = '{8'h40, 8'h5b, 8'h5d, 8'h5e, 8'h2d, 8'h5c, 8'h5f, 8'h70};
	logic [7:0] wv[8] = '{8'h70, 8'hd7, 8'hbf, 8'h3f, 8'h1d, 8'h00, 8'h00, 8'h00};
	logic [7:0] ca[7] = '{8'h5d, 8'h5b, 8'h59, 8'h5e, 8'h41, 8'h58, 8'h40};
	logic [7:0] cv[7] = '{8'h3e, 8'h45, 8'h12, 8'h15, 8'h2f, 8'ha5, 8'h40};
	always #12.5 ref_clk = ~ref_clk;
	vds_slicer_setup #(.FIFO_DEPTH(4)) uut (.ref_clk(ref_clk), .rstn(rstn),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .video_text_arbitration_sel(sel),
		.field_start(fs), .field_id(fid), .line_start(ls), .scl_window(scl),
		.vid_valid(vv), .vid_data(vid_data), .vid_line_end(vle), .vid_ready(vid_ready),
		.slc_byte_valid(sbv), .slc_byte(sb), .slc_byte_ready(sbr), .slc_done(sdn),
		.slc_detect(sdet), .slc_enable(en), .slc_line_type(lt), .slc_h_offset(slice_h_offset),
		.slc_framing_code(fc), .slc_field_offset(slice_field_offset), .slc_select_a(sela),
		.slc_flag_event(ev), .out_valid(ov), .out_data(od), .out_ready(ordy));
	vds_core_model core (.ref_clk(ref_clk), .slc_byte(sb), .slc_byte_valid(sbv),
		.slc_byte_ready(sbr), .slc_done(sdn), .slc_detect(sdet), .out_ready(ordy),
		.stall(stall));
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		chk(11'(g), 11'(e));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{1'b1, 1'b0, a, d};
		@(negedge ref_clk);
		reg_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		reg_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge ref_clk);
		reg_req = '0;
		@(negedge ref_clk);
		chk_byte(reg_rdata, e);
	endtask
	task automatic field(input int n);
		@(negedge ref_clk);
		fs = 1'b1;
		@(negedge ref_clk);
		fs = 1'b0;
		repeat (n) begin
			@(negedge ref_clk);
			ls = 1'b1;
			@(negedge ref_clk);
			ls = 1'b0;
		end
	endtask
	task automatic line_end(input logic [7:0] d);
		@(negedge ref_clk);
		vv = 1'b1;
		vle = 1'b1;
		vid_data = d;
		while (!vid_ready) @(negedge ref_clk);
		@(negedge ref_clk);
		vv = 1'b0;
		vle = 1'b0;
		vid_data = ~d;
	endtask
	task automatic expect_out(input logic [7:0] e[$]);
		int k;
		foreach (e[i]) begin
			k = 0;
			do begin
				@(negedge ref_clk);
				#1;
				k++;
			end while (!(ov && ordy) && k < 60);
			chk_byte(od, e[i]);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		int k;
		repeat (12) @(negedge ref_clk);
		rstn = 1'b1;
		foreach (ra[i]) rd(ra[i], rv[i]);
		foreach (wa[i]) begin
			wr(wa[i], 8'hff);
			rd(wa[i], wv[i]);
		end
		foreach (ca[i]) wr(ca[i], cv[i]);
		sel = 2'h3;
		scl = 1'b1;
		field(0);
		@(negedge ref_clk);
		chk(slice_h_offset, 11'h512);
		chk(11'({slice_field_offset, sela}), 11'h001);
		chk_byte(fc, 8'ha5);
		wr(8'h59, 8'h00);
		chk(slice_h_offset, 11'h512);
		field(5);
		repeat (2) @(negedge ref_clk);
		chk(slice_h_offset, 11'h500);
		chk(11'({en, lt}), 11'h012);
		core.done('{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h9});
		chk(11'(ev), 11'h00a);
		rd(8'h60, 8'h54);
		rd(8'h61, 8'h00);
		rd(8'h62, 8'h69);
		wr(8'h60, 8'hff);
		rd(8'h60, 8'h54);
		wr(8'h2d, 8'h01);
		core.done('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h3});
		chk(11'(ev), 11'h000);
		rd(8'h62, 8'h63);
		core.push(8'h11, 1'b0, 1'b0);
		core.push(8'h22, 1'b1, 1'b0);
		fork
			line_end(8'h77);
			expect_out('{8'h77, 8'hff, 8'h00, 8'h00, 8'h84, 8'h15, 8'h11, 8'h22,
				8'hff, 8'h00, 8'h00, 8'ha4});
		join
		for (int i = 0; i < 4; i++) core.push(8'h31 + 8'(i), 1'(i == 3), 1'b0);
		chk(11'(sbr), 11'h000);
		core.push(8'h99, 1'b1, 1'b1);
		chk(11'(ev), 11'h001);
		wr(8'h5d, 8'h3d);
		stall = 1'b1;
		fork
			line_end(8'h78);
			expect_out('{8'h78, 8'hff, 8'h00, 8'h00, 8'h04, 8'h15, 8'h31, 8'h32,
				8'h33, 8'h34, 8'hff, 8'h00, 8'h00, 8'h24});
		join
		stall = 1'b0;
		sel = 2'h0;
		core.push(8'h41, 1'b1, 1'b0);
		fork
			line_end(8'h66);
			expect_out('{8'h66});
		join
		k = 0;
		repeat (30) begin
			@(negedge ref_clk);
			if (ov !== 1'b0) k++;
		end
		chk(11'(k), 11'h0);
		// 625-line offsets, second field, low type nibble
		wr(8'h41, 8'h2c);
		wr(8'h5a, 8'h03);
		wr(8'h5b, 8'h03);
		fid = 1'b1;
		field(2);
		repeat (2) @(negedge ref_clk);
		chk(slice_h_offset, 11'h300);
		chk(11'({slice_field_offset, sela}), 11'h000);
		chk(11'(lt), 11'h00c);
		core.done('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1});
		rd(8'h61, 8'h20);
		rd(8'h62, 8'h31);
		print_verdict();
	end
endmodule
